/* File: frame_lane.sv */
`timescale 1ns/1ps
module frame_lane (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       start,
  input  wire logic       byte_en,
  input  wire logic       data_eq,
  input  wire logic [1:0] code,
  output logic            hit_q
);
  import sfm_pkg::*;

  logic live_q;  // Lane still walking its mask
  logic ok_q;    // No checked byte has differed yet

  // A new frame restarts the lane on its first byte
  wire go     = byte_en & (start | live_q);
  wire ok_now = start | ok_q;
  wire is_end = (code == CODE_END);

  // Lane stays live until its end code is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      live_q <= 1'b0;
    end else if (go && is_end) begin
      live_q <= 1'b0;
    end else if (start && byte_en) begin
      live_q <= 1'b1;
    end
  end

  // Codes 00 and 10 leave the verdict alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ok_q <= 1'b0;
    end else if (go) begin
      ok_q <= ok_now & ~(code == CODE_CHECK & ~data_eq);
    end
  end

  // Hit only on the end code with a clean record
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= go & is_end & ok_now;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_lane_hit;
    go && is_end && ok_now |=> hit_q;
  endproperty
  a_lane_hit: assert property (p_lane_hit)
    else $error("lane missed a clean end code");

  property p_lane_miss;
    go && code == CODE_CHECK && !data_eq ##1 !start[*1] ##0 go && is_end
      |=> !hit_q;
  endproperty
  a_lane_miss: assert property (p_lane_miss)
    else $error("lane hit after a mismatch");

  c_lane_hit: cover property (hit_q);
endmodule : frame_lane

/* File: sfm_pkg.sv */
package sfm_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] A_WAKE_CFG   = 8'h00;
  localparam logic [7:0] A_OP_MODE    = 8'h04;
  localparam logic [7:0] A_PORT_SEL   = 8'h08;
  localparam logic [7:0] A_PORT_DATA  = 8'h0c;
  localparam logic [7:0] A_PWR        = 8'h10;
  localparam logic [7:0] A_IRQ_STAT   = 8'h14;
  localparam logic [7:0] A_IRQ_MASK   = 8'h18;
  // Field positions and codes
  localparam int         SAMPLE_EN_BIT = 28;
  localparam int         MODE_LSB      = 25;
  localparam int         MODE_MSB      = 28;
  localparam logic [3:0] MODE_TEST     = 4'h3;
  localparam int         SEL_LSB       = 3;
  localparam int         SEL_MSB       = 8;
  localparam logic [5:0] SEL_TX        = 6'h32;
  localparam logic [5:0] SEL_RX        = 6'h35;
  localparam logic [5:0] SEL_RST       = 6'h38;
  // Pointer reset port bits
  localparam int         PR_TX_WR0     = 0;
  localparam int         PR_TX_RD0     = 1;
  localparam int         PR_RX_WR0     = 2;
  localparam int         PR_RX_RD0     = 3;
  localparam int         PR_TX_WRH     = 5;
  localparam int         PR_RX_WRH     = 6;
  localparam int         PR_WIDTH      = 7;
  localparam logic [7:0] PTR_HALF      = 8'h80;
  // Power control and status fields
  localparam int         PWR_EN_BIT    = 8;
  localparam int         PWR_FLAG_BIT  = 15;
  localparam logic [1:0] PWR_D3HOT     = 2'h3;
  // Matching geometry and mask codes
  localparam int         FRAMES        = 8;
  localparam int         BUF_WORDS     = 256;
  localparam logic [6:0] LAST_POS      = 7'h7f;
  localparam logic [1:0] CODE_CHECK    = 2'h1;
  localparam logic [1:0] CODE_END      = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // One received byte of the incoming frame stream
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } rx_byte_t;

  // Write captured in the address phase
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } bus_req_t;

  // Matcher sequencing
  typedef enum logic [2:0] {
    M_IDLE  = 3'b001,
    M_RUN   = 3'b010,
    M_DRAIN = 3'b100
  } match_st_t;
endpackage : sfm_pkg

/* File: wake_sample_frame_matcher.sv */
`timescale 1ns/1ps
module wake_sample_frame_matcher (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire sfm_pkg::rx_byte_t rx_in,
  output logic                   pme_o,
  output logic                   pme_oe_n,
  output logic                   irq
);
  import sfm_pkg::*;

  // Bus side state
  bus_req_t        req_q;        // Pending write data phase
  logic [31:0]     wake_cfg_q;   // Wake configuration register
  logic [31:0]     op_mode_q;    // Operation mode register
  logic [31:0]     port_sel_q;   // Port select register
  logic [1:0]      pwr_state_q;  // Power state field
  logic            power_event_enable_q;     // Power event enable
  logic            pme_flag_q;   // Power event flag, sticky
  logic            irq_stat_q;   // Sticky wake match status
  logic            irq_mask_q;   // Interrupt mask, 1 passes
  logic [PR_WIDTH-1:0] prst_q;   // Pointer reset port pattern

  // Buffer pointers, word indices
  logic [7:0]      tx_wp_q;
  logic [7:0]      tx_rp_q;
  logic [7:0]      rx_wp_q;
  logic [7:0]      rx_rp_q;

  // Transmit buffer holds masks, receive buffer holds samples
  logic [31:0]     tx_mem [BUF_WORDS];
  logic [31:0]     rx_mem [BUF_WORDS];

  // Matcher state
  match_st_t       st_q;
  logic [6:0]      pos_q;        // Byte position in frame
  logic [FRAMES-1:0] hit;        // Per frame match pulses
  logic [31:0]     rd_d;         // Read data for the bus

  // Address phase accepted for whole words only
  wire take    = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
  wire [7:0] a = haddr[7:0];
  wire test_mode = op_mode_q[MODE_MSB:MODE_LSB] == MODE_TEST;
  wire [5:0] sel = port_sel_q[SEL_MSB:SEL_LSB];

  // Data port writes reach storage only in test mode
  wire data_wr = req_q.wr & (req_q.addr == A_PORT_DATA) & test_mode;
  wire tx_we   = data_wr & (sel == SEL_TX);
  wire rx_we   = data_wr & (sel == SEL_RX);
  wire prst_we = data_wr & (sel == SEL_RST);

  // Test mode reads of the data port pop the selected buffer
  wire rd_port = take & ~hwrite & (a == A_PORT_DATA) & test_mode;
  wire tx_pop  = rd_port & (sel == SEL_TX);
  wire rx_pop  = rd_port & (sel == SEL_RX);

  // Register write strobes in the data phase
  wire wr_wake = req_q.wr & (req_q.addr == A_WAKE_CFG);
  wire wr_mode = req_q.wr & (req_q.addr == A_OP_MODE);
  wire wr_sel  = req_q.wr & (req_q.addr == A_PORT_SEL);
  wire wr_pwr  = req_q.wr & (req_q.addr == A_PWR);
  wire wr_ist  = req_q.wr & (req_q.addr == A_IRQ_STAT);
  wire wr_imsk = req_q.wr & (req_q.addr == A_IRQ_MASK);

  // Matching runs only in the suspended hot state, outside test mode
  wire det_en = wake_cfg_q[SAMPLE_EN_BIT] & (pwr_state_q == PWR_D3HOT)
              & ~test_mode;
  wire start   = (st_q == M_IDLE) & det_en & rx_in.valid;
  wire byte_en = rx_in.valid & (start | (st_q == M_RUN));
  wire hit_any = |hit;

  // Capture the write address; data follows next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else begin
      req_q.wr   <= take & hwrite;
      req_q.addr <= a;
    end
  end

  // Read data mux, unmapped offsets read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (a)
      A_WAKE_CFG: rd_d = wake_cfg_q;
      A_OP_MODE:  rd_d = op_mode_q;
      A_PORT_SEL: rd_d = port_sel_q;
      A_PORT_DATA: begin
        if (!test_mode) begin
          rd_d = 32'h0000_0000;
        end else if (sel == SEL_TX) begin
          rd_d = tx_mem[tx_rp_q];
        end else if (sel == SEL_RX) begin
          rd_d = rx_mem[rx_rp_q];
        end else if (sel == SEL_RST) begin
          rd_d = {25'h000_0000, prst_q};
        end
      end
      A_PWR: begin
        rd_d[PWR_FLAG_BIT] = pme_flag_q;
        rd_d[PWR_EN_BIT]   = power_event_enable_q;
        rd_d[1:0]          = pwr_state_q;
      end
      A_IRQ_STAT: rd_d[0] = irq_stat_q;
      A_IRQ_MASK: rd_d[0] = irq_mask_q;
      default:    rd_d = 32'h0000_0000;
    endcase
  end

  // Zero wait state slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // Plain software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_cfg_q <= 32'h0000_0000;
      op_mode_q  <= 32'h0000_0000;
      port_sel_q <= 32'h0000_0000;
      irq_mask_q <= 1'b0;
    end else begin
      if (wr_wake) wake_cfg_q <= hwdata;
      if (wr_mode) op_mode_q  <= hwdata;
      if (wr_sel)  port_sel_q <= hwdata;
      if (wr_imsk) irq_mask_q <= hwdata[0];
    end
  end

  // Pointer reset pattern stays in force until 00h is written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prst_q <= '0;
    end else if (prst_we) begin
      prst_q <= hwdata[PR_WIDTH-1:0];
    end
  end

  // Storage writes; no reset so the arrays map onto RAM
  always_ff @(posedge hclk) begin
    if (tx_we) begin
      tx_mem[tx_wp_q] <= hwdata;
    end
    if (rx_we) begin
      rx_mem[rx_wp_q] <= hwdata;
    end
  end

  // Transmit write pointer; clear beats set when both held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wp_q <= '0;
    end else if (prst_q[PR_TX_WR0]) begin
      tx_wp_q <= '0;
    end else if (prst_q[PR_TX_WRH]) begin
      tx_wp_q <= PTR_HALF;
    end else if (tx_we) begin
      tx_wp_q <= tx_wp_q + 8'h01;
    end
  end

  // Receive write pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp_q <= '0;
    end else if (prst_q[PR_RX_WR0]) begin
      rx_wp_q <= '0;
    end else if (prst_q[PR_RX_WRH]) begin
      rx_wp_q <= PTR_HALF;
    end else if (rx_we) begin
      rx_wp_q <= rx_wp_q + 8'h01;
    end
  end

  // Each read pointer advances on a test mode data port read of its own buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_rp_q <= '0;
      rx_rp_q <= '0;
    end else begin
      if (prst_q[PR_TX_RD0]) begin
        tx_rp_q <= '0;
      end else if (tx_pop) begin
        tx_rp_q <= tx_rp_q + 8'h01;
      end
      if (prst_q[PR_RX_RD0]) begin
        rx_rp_q <= '0;
      end else if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 8'h01;
      end
    end
  end

  // Frame walk: compare up to 128 bytes, then drain the rest
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= M_IDLE;
    end else begin
      case (st_q)
        M_IDLE: begin
          if (start && !rx_in.last) begin
            st_q <= M_RUN;
          end
        end
        M_RUN: begin
          if (byte_en && rx_in.last) begin
            st_q <= M_IDLE;
          end else if (byte_en && pos_q == LAST_POS) begin
            st_q <= M_DRAIN;
          end
        end
        M_DRAIN: begin
          if (rx_in.valid && rx_in.last) begin
            st_q <= M_IDLE;
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  // Position returns to zero whenever the comparison concludes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_q <= '0;
    end else if (byte_en) begin
      if (rx_in.last || pos_q == LAST_POS) begin
        pos_q <= '0;
      end else begin
        pos_q <= pos_q + 7'h01;
      end
    end
  end

  // Group 0 serves frames 0-3, group 1 frames 4-7 from 080H
  logic [31:0] dat_w [2];
  logic [31:0] msk_w [2];
  always_comb begin
    dat_w[0] = rx_mem[{1'b0, pos_q}];
    dat_w[1] = rx_mem[{1'b1, pos_q}];
    msk_w[0] = tx_mem[{3'h0, pos_q[6:2]}];
    msk_w[1] = tx_mem[{3'h4, pos_q[6:2]}];
  end

  // One lane per sample frame; a word carries four frames
  for (genvar f = 0; f < FRAMES; f++) begin : g_lane
    localparam int G = f / 4;
    localparam int L = f % 4;
    wire [7:0] mb = msk_w[G][8*L +: 8];
    wire [1:0] cd = mb[{pos_q[1:0], 1'b0} +: 2];
    wire       eq = dat_w[G][8*L +: 8] == rx_in.data;
    frame_lane u_lane (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (start),
      .byte_en (byte_en),
      .data_eq (eq),
      .code    (cd),
      .hit_q   (hit[f])
    );
  end

  // Power control; the event flag sets ahead of a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_state_q <= '0;
      power_event_enable_q    <= 1'b0;
      pme_flag_q  <= 1'b0;
    end else begin
      if (wr_pwr) begin
        pwr_state_q <= hwdata[1:0];
        power_event_enable_q    <= hwdata[PWR_EN_BIT];
      end
      if (hit_any) begin
        pme_flag_q <= 1'b1;
      end else if (wr_pwr && hwdata[PWR_FLAG_BIT]) begin
        pme_flag_q <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, write one to clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= 1'b0;
    end else if (hit_any) begin
      irq_stat_q <= 1'b1;
    end else if (wr_ist && hwdata[0]) begin
      irq_stat_q <= 1'b0;
    end
  end

  // Open drain event pin pulls low while flagged and enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pme_o    <= 1'b0;
      pme_oe_n <= 1'b1;
      irq      <= 1'b0;
    end else begin
      pme_o    <= 1'b0;
      pme_oe_n <= ~(pme_flag_q & power_event_enable_q);
      irq      <= irq_stat_q & irq_mask_q;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_enable;
    st_q == M_IDLE && !det_en |=> st_q == M_IDLE;
  endproperty
  a_enable: assert property (p_enable)
    else $error("matcher left idle while disabled");

  property p_test_mode;
    tx_we || rx_we || prst_we |-> test_mode;
  endproperty
  a_test_mode: assert property (p_test_mode)
    else $error("buffer access outside test mode");

  property p_end_packet;
    st_q == M_RUN && byte_en && rx_in.last |=> st_q == M_IDLE && pos_q == 0;
  endproperty
  a_end_packet: assert property (p_end_packet)
    else $error("comparison not closed at packet end");

  property p_max_len;
    st_q == M_RUN && byte_en && !rx_in.last && pos_q == LAST_POS
      |=> st_q == M_DRAIN ##1 !(|hit);
  endproperty
  a_max_len: assert property (p_max_len)
    else $error("comparison ran past 128 bytes");

  property p_prst;
    prst_we |=> prst_q == $past(hwdata[PR_WIDTH-1:0]);
  endproperty
  a_prst: assert property (p_prst)
    else $error("pointer reset port not written");

  property p_advance;
    tx_we && !prst_q[PR_TX_WR0] && !prst_q[PR_TX_WRH]
      |=> tx_wp_q == $past(tx_wp_q) + 8'h01;
  endproperty
  a_advance: assert property (p_advance)
    else $error("write pointer did not advance");

  property p_half;
    prst_q[PR_RX_WRH] && !prst_q[PR_RX_WR0] |=> rx_wp_q == PTR_HALF;
  endproperty
  a_half: assert property (p_half)
    else $error("receive pointer not set to half");

  property p_pme;
    hit_any && power_event_enable_q && !wr_pwr |=> pme_flag_q ##1 !pme_oe_n;
  endproperty
  a_pme: assert property (p_pme)
    else $error("wake event did not drive the pin");

  c_match: cover property (hit_any ##2 !pme_oe_n);
  c_drain: cover property (st_q == M_DRAIN);
  c_half:  cover property (tx_we && tx_wp_q == PTR_HALF);
endmodule : wake_sample_frame_matcher

/* File: wake_sample_frame_matcher_bench.sv */
`timescale 1ns/1ps
module wake_sample_frame_matcher_bench;
  import sfm_pkg::*;
  logic              hclk;       // 200 MHz bus clock
  logic              hresetn;    // Active low reset
  logic              hsel;       // Slave select
  logic [31:0]       haddr;      // Bus address
  logic [1:0]        htrans;     // Transfer type
  logic              hwrite;     // Write strobe
  logic [2:0]        hsize;      // Transfer size
  logic [31:0]       hwdata;     // Write data
  logic              hready;     // Bus ready, the one slave's answer
  logic              hreadyout;  // Slave ready out
  logic              hresp;      // Slave response
  logic [31:0]       hrdata;     // Read data
  rx_byte_t          rx_in;      // Received byte stream
  logic              pme_o;      // Power event drive level
  logic              pme_oe_n;   // Power event enable, low pulls pin
  logic              irq;        // Level interrupt
  int                miscompares; // Mismatches seen
  int                num_checks;  // Comparisons made
  int                seed;        // Random seed
  logic [31:0]       rx_mem [256]; // Model of sample data buffer
  logic [31:0]       tx_mem [256]; // Model of mask buffer
  logic [31:0]       q;           // Scratch read word
  logic              wake_en;     // Model copy of the wake enable bit
  logic              m;           // Expected match of last frame

  assign hready = hreadyout;

  wake_sample_frame_matcher dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_in(rx_in), .pme_o(pme_o),
    .pme_oe_n(pme_oe_n), .irq(irq)
  );

  // Free running clock
  always #2.5 hclk = ~hclk;

  // Word comparison
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // Single bit comparison
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // Verdict, the only place the run ends
  task automatic final_report;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // One single transfer; waits on hready rather than assuming latency
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  // Register read compared with an expected word
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, a, 32'h0000_0000, got);
    chk_word(got, exp);
    chk_bit(hresp, 1'b0);
  endtask : rd_chk

  // Route the data port
  task automatic sel(input logic [5:0] s);
    wr(A_PORT_SEL, 32'({s, 3'h0}));
  endtask : sel

  // Pointer reset pattern then release, as software must do
  task automatic ptr(input logic [6:0] v);
    sel(SEL_RST);
    wr(A_PORT_DATA, 32'(v));
    wr(A_PORT_DATA, 32'h0000_0000);
  endtask : ptr

  // Reference matcher over all eight frames
  function automatic logic model(input logic [7:0] b[$]);
    logic [1:0] code;
    int         base;
    logic       ok;
    for (int f = 0; f < FRAMES; f++) begin
      ok = 1'b1;
      base = (f / 4) * 128;
      for (int p = 0; p < b.size() && p < 128; p++) begin
        code = tx_mem[base + p / 4][8 * (f % 4) + 2 * (p % 4) +: 2];
        if (code == 2'h3) begin
          if (ok) return 1'b1;
          break;
        end else if (code == 2'h1 &&
                     b[p] != rx_mem[base + p][8 * (f % 4) +: 8]) begin
          ok = 1'b0;
        end
      end
    end
    return 1'b0;
  endfunction : model

  // Send a frame built from frame f's samples, one byte possibly spoilt
  task automatic send(input int f, input int bad, input int len,
                      output logic exp);
    logic [7:0] b[$];
    logic [7:0] v;
    for (int p = 0; p < len; p++) begin
      v = 8'($random(seed));
      if (p == 0 || p == 3 || p == 4 || p == 5) begin
        v = rx_mem[(f / 4) * 128 + p][8 * (f % 4) +: 8];
      end
      if (p == bad) v = ~v;
      b.push_back(v);
    end
    exp = model(b) & wake_en;
    foreach (b[i]) begin
      @(posedge hclk);
      rx_in <= '{valid: 1'b1, last: (i == b.size() - 1), data: b[i]};
    end
    @(posedge hclk);
    rx_in <= '0;
    // Hit, flag and pin each take one register stage
    repeat (4) @(posedge hclk);
    #1;
  endtask : send

  // Clear the power event flag and the interrupt status
  task automatic clear_ev;
    wr(A_PWR, 32'h0000_8103);
    wr(A_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    #1;
    chk_bit(pme_oe_n, 1'b1);
    chk_bit(pme_o, 1'b0);
    chk_bit(irq, 1'b0);
  endtask : clear_ev

  // Watchdog sized well above the expected run
  initial begin
    #200000;
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    final_report;
  end

  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = '0;
    rx_in = '0;
    seed = 74974;
    wake_en = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk_word(hrdata, 32'h0000_0000);
    chk_bit(hreadyout, 1'b1);
    chk_bit(hresp, 1'b0);
    chk_bit(pme_o, 1'b0);
    chk_bit(pme_oe_n, 1'b1);
    chk_bit(irq, 1'b0);
    // Data port is closed outside test mode
    sel(SEL_RX);
    wr(A_PORT_DATA, 32'hdead_beef);
    rd_chk(A_PORT_DATA, 32'h0000_0000);
    rd_chk(8'h1c, 32'h0000_0000);
    // Traffic is halted, so test mode may be entered
    wr(A_OP_MODE, 32'h0600_0000);
    for (int g = 0; g < 2; g++) begin
      ptr(g == 0 ? 7'h05 : 7'h60);
      sel(SEL_RX);
      for (int i = 0; i < 8; i++) begin
        rx_mem[g * 128 + i] = $random(seed);
        wr(A_PORT_DATA, rx_mem[g * 128 + i]);
      end
      sel(SEL_TX);
      // Check 0,3,4,5; ignore 1,2 with both ignore codes; end at 6
      tx_mem[g * 128] = 32'h6161_6161;
      tx_mem[g * 128 + 1] = 32'h3535_3535;
      wr(A_PORT_DATA, tx_mem[g * 128]);
      wr(A_PORT_DATA, tx_mem[g * 128 + 1]);
    end
    // Read back from offset zero of both buffers
    ptr(7'h0a);
    sel(SEL_TX);
    for (int i = 0; i < 2; i++) rd_chk(A_PORT_DATA, tx_mem[i]);
    sel(SEL_RX);
    for (int i = 0; i < 8; i++) rd_chk(A_PORT_DATA, rx_mem[i]);
    // Pointer reset port reads back its released pattern
    sel(SEL_RST);
    rd_chk(A_PORT_DATA, 32'h0000_0000);
    // Leave test mode, then suspend with the event enabled
    wr(A_OP_MODE, 32'h0000_0000);
    wr(A_WAKE_CFG, 32'h1000_0000);
    wake_en = 1'b1;
    wr(A_PWR, 32'h0000_0103);
    wr(A_IRQ_MASK, 32'h0000_0001);
    rd_chk(A_IRQ_MASK, 32'h0000_0001);
    // Every frame matches on its own samples
    for (int f = 0; f < FRAMES; f++) begin
      send(f, -1, 8, m);
      chk_bit(pme_oe_n, ~m);
      chk_bit(irq, m);
      rd_chk(A_IRQ_STAT, {31'h0000_0000, m});
      clear_ev;
    end
    // A spoilt checked byte, then a spoilt ignored byte that still matches
    send(2, 4, 8, m);
    chk_bit(pme_oe_n, ~m);
    send(5, 1, 8, m);
    chk_bit(pme_oe_n, ~m);
    // The flag is sticky, so clear it before a frame that must not match
    clear_ev;
    send(1, -1, 5, m);
    chk_bit(pme_oe_n, ~m);
    clear_ev;
    // A packet past 128 bytes drains its tail and still matches
    send(4, -1, 130, m);
    chk_bit(pme_oe_n, ~m);
    clear_ev;
    // Masked interrupt, pin released by dropping the enable
    wr(A_IRQ_MASK, 32'h0000_0000);
    send(6, -1, 8, m);
    chk_bit(pme_oe_n, ~m);
    chk_bit(irq, 1'b0);
    rd_chk(A_IRQ_STAT, {31'h0000_0000, m});
    wr(A_PWR, 32'h0000_0003);
    repeat (2) @(posedge hclk);
    #1;
    chk_bit(pme_oe_n, 1'b1);
    clear_ev;
    // With the wake bit off nothing is detected
    wr(A_WAKE_CFG, 32'h0000_0000);
    wake_en = 1'b0;
    send(3, -1, 8, m);
    chk_bit(pme_oe_n, 1'b1);
    rd_chk(A_IRQ_STAT, 32'h0000_0000);
    final_report;
  end
endmodule : wake_sample_frame_matcher_bench
